// ===== hw/dscw_core.sv
// Summary of operation
// - Status bit 8 shows halt active
// - Status bit 9 shows fieldbus controls motion
// - Status bit 13 set on blocking error
// - Status bit 14 cleared when mode starts
// - Bit 14 set after standstill, unless chained
// - Status bit 15 shows valid zero point
// - Enable input rise switches on from ready; fall disables power stage
// - Fault-reset input rising edge resets error
// - Control word bit meanings; bit 8 halts
// - Shutdown command goes to ready-to-switch-on
// - Switch on / enable operation commands
// - Disable voltage goes to switch-on-disabled
// - Quick stop goes to quick-stop-active
// - Bit 7 rising edge resets fault
// - Selected mode starts with power stage
// - Mode encoding; writes take effect when no mode runs or on halt at standstill
// - Mode change only when stopped
// - CSP interpolates received positions linearly
// - CSP status bit 12 target used
// - CSP starts in state 6, ends leaving
// - State coded on status bits 0-3,5,6
module dscw_core (
  input  wire logic                   ref_clk_i,        // 50 MHz
  input  wire logic                   rstn_i,           // Synchronous, active low
  input  wire dscw_pkg::dscw_par_req_t par_req_i,       // Fieldbus parameter access
  input  wire logic                   din_enable_i,     // Power-enable signal input
  input  wire logic                   din_fault_rst_i,  // Error-reset signal input
  input  wire dscw_pkg::dscw_drive_t  drive_i,          // Motion core conditions
  output logic [31:0]                 par_rdata_o,      // Read data
  output logic                        par_rvalid_o,     // Read data valid pulse
  output logic [15:0]                 status_word_o,    // drive_status_word
  output logic [15:0]                 active_mode_o,    // active_mode_readback
  output logic                        power_stage_o,    // Power stage enabled
  output logic                        halt_o,           // Halt request to motion core
  output logic                        csp_active_o,     // CSP mode processing
  output logic [31:0]                 csp_setpoint_o    // Interpolated position
);

  // Power stage is live in these states
  function automatic logic power_on(input dscw_pkg::dscw_state_t s);
    power_on = (s == dscw_pkg::ST_OP_ENABLED) || (s == dscw_pkg::ST_QUICK_STOP) ||
               (s == dscw_pkg::ST_FAULT_REACT);
  endfunction : power_on

  // Register file and machine state
  logic [15:0]           ctrl_reg,     ctrl_next;      // drive_control_word
  logic [15:0]           msel_reg,     msel_next;      // mode_select
  logic [15:0]           mact_reg,     mact_next;      // Active mode
  logic [31:0]           tgt_reg,      tgt_next;       // target_position
  dscw_pkg::dscw_state_t state_reg,    state_next;     // Operating state
  logic [1:0]            din_reg,      din_next;       // Signal inputs, last cycle
  logic                  xend_reg,     xend_next;      // Processing finished flag
  logic [15:0]           stat_reg,     stat_next;      // Status word
  logic [31:0]           rdata_reg,    rdata_next;     // Read data
  logic                  rvalid_reg,   rvalid_next;    // Read valid
  logic                  pwr_reg,      pwr_next;       // Power stage output
  logic                  csp_reg,      csp_next;       // CSP running
  logic [31:0]           sp_reg,       sp_next;        // Interpolated setpoint
  logic [31:0]           step_reg,     step_next;      // Per-clock increment
  logic [4:0]            icnt_reg,     icnt_next;      // Steps left

  // Decoded events
  logic        cw_wr;            // Control word written this cycle
  logic        tgt_wr;           // Target written this cycle
  logic [15:0] cw;               // Word being written
  logic [1:0]  din_now;          // Current signal inputs
  logic [1:0]  din_rise;         // Rising edges
  logic [1:0]  din_fall;         // Falling edges
  logic        fr_edge;          // Any fault reset edge
  logic        cmd_ok;           // Level command allowed (bit 7 low)
  logic        cmd_disable;      // Disable voltage
  logic        cmd_qstop;        // Quick stop
  logic        cmd_shutdown;     // Shutdown
  logic        cmd_swon;         // Switch on / disable operation
  logic        cmd_enop;         // Enable operation
  logic        mode_run;         // A mode is processing
  logic        run_start;        // Processing starts this cycle

  assign cw_wr   = par_req_i.wr && (par_req_i.addr == dscw_pkg::ADDR_CONTROL);
  assign tgt_wr  = par_req_i.wr && (par_req_i.addr == dscw_pkg::ADDR_TARGET);
  assign cw      = par_req_i.wdata[15:0];
  assign din_now = {din_fault_rst_i, din_enable_i};

  // Edge detectors for both signal inputs
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_din_edge
      assign din_rise[gi] = din_now[gi] && !din_reg[gi];
      assign din_fall[gi] = !din_now[gi] && din_reg[gi];
    end
  endgenerate

  // Commands only act at the moment a control word arrives
  always_comb
  begin
    fr_edge      = (cw_wr && cw[dscw_pkg::CW_FAULT_RESET] && !ctrl_reg[dscw_pkg::CW_FAULT_RESET])
                   || din_rise[1];
    cmd_ok       = cw_wr && !cw[dscw_pkg::CW_FAULT_RESET];
    cmd_disable  = cmd_ok && !cw[dscw_pkg::CW_EN_VOLTAGE];
    cmd_qstop    = cmd_ok && cw[dscw_pkg::CW_EN_VOLTAGE] && !cw[dscw_pkg::CW_QUICK_STOP];
    cmd_shutdown = cmd_ok && (cw[2:0] == 3'b110);
    cmd_swon     = cmd_ok && (cw[3:0] == 4'b0111);
    cmd_enop     = cmd_ok && (cw[3:0] == 4'b1111);
  end

  // Operating state machine
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      dscw_pkg::ST_NOT_READY:
        state_next = dscw_pkg::ST_SW_DISABLED;
      dscw_pkg::ST_SW_DISABLED:
        // Without bus voltage the drive stays here
        if (cmd_shutdown && drive_i.dc_ok)
          state_next = dscw_pkg::ST_READY;
      dscw_pkg::ST_READY:
        if (cmd_disable || cmd_qstop)
          state_next = dscw_pkg::ST_SW_DISABLED;
        else if (cmd_swon || cmd_enop || din_rise[0])
          state_next = dscw_pkg::ST_SWITCHED_ON;
      dscw_pkg::ST_SWITCHED_ON:
        if (cmd_disable || cmd_qstop)
          state_next = dscw_pkg::ST_SW_DISABLED;
        else if (cmd_shutdown)
          state_next = dscw_pkg::ST_READY;
        else if (cmd_enop)
          state_next = dscw_pkg::ST_OP_ENABLED;
      dscw_pkg::ST_OP_ENABLED:
        if (cmd_disable || din_fall[0])
          state_next = dscw_pkg::ST_SW_DISABLED;
        else if (cmd_qstop || drive_i.err_class1)
          state_next = dscw_pkg::ST_QUICK_STOP;
        else if (cmd_shutdown)
          state_next = dscw_pkg::ST_READY;
        else if (cmd_swon)
          state_next = dscw_pkg::ST_SWITCHED_ON;
      dscw_pkg::ST_QUICK_STOP:
        if (cmd_disable || din_fall[0])
          state_next = dscw_pkg::ST_SW_DISABLED;
        else if (fr_edge || cmd_enop)
          state_next = dscw_pkg::ST_OP_ENABLED;
      dscw_pkg::ST_FAULT_REACT:
        if (drive_i.react_done)
          state_next = dscw_pkg::ST_FAULT;
      dscw_pkg::ST_FAULT:
        if (fr_edge)
          state_next = dscw_pkg::ST_SW_DISABLED;
      default:
        state_next = dscw_pkg::ST_NOT_READY;
    endcase
    // Severe errors override any command
    if (drive_i.err_fatal && (state_reg != dscw_pkg::ST_FAULT_REACT) && (state_reg != dscw_pkg::ST_FAULT))
      state_next = dscw_pkg::ST_FAULT_REACT;
  end

  // Mode selection and processing flags
  always_comb
  begin
    ctrl_next = cw_wr ? cw : ctrl_reg;
    msel_next = (par_req_i.wr && (par_req_i.addr == dscw_pkg::ADDR_MODE_SEL)) ? par_req_i.wdata[15:0]
                                                                              : msel_reg;
    tgt_next  = tgt_wr ? par_req_i.wdata : tgt_reg;
    din_next  = din_now;
    mode_run  = (state_reg == dscw_pkg::ST_OP_ENABLED) && (mact_reg != dscw_pkg::MODE_NONE);
    // A new selection replaces the active one only when no mode runs or on halt at standstill
    if (!mode_run || (ctrl_reg[dscw_pkg::CW_HALT] && drive_i.standstill))
      mact_next = msel_reg;
    else
      mact_next = mact_reg;
    run_start = (state_next == dscw_pkg::ST_OP_ENABLED) && (mact_next != dscw_pkg::MODE_NONE) &&
                ((state_reg != dscw_pkg::ST_OP_ENABLED) || (mact_next != mact_reg));
    // Cleared on start; set on standstill after end or halt, so chained starts keep it low
    if (run_start)
      xend_next = 1'b0;
    else if ((!mode_run || ctrl_reg[dscw_pkg::CW_HALT]) && drive_i.standstill)
      xend_next = 1'b1;
    else
      xend_next = xend_reg;
    pwr_next = power_on(state_next);
    csp_next = (state_next == dscw_pkg::ST_OP_ENABLED) && (mact_next == dscw_pkg::MODE_CSP);
  end

  // Linear interpolation toward each received position
  always_comb
  begin
    sp_next   = sp_reg;
    step_next = step_reg;
    icnt_next = icnt_reg;
    if (!csp_reg)
    begin
      // Outside the mode the setpoint simply parks on the target
      sp_next   = tgt_reg;
      icnt_next = 5'h00;
    end
    else if (tgt_wr)
    begin
      step_next = 32'($signed(par_req_i.wdata - sp_reg) >>> dscw_pkg::INTERP_SHIFT);
      icnt_next = dscw_pkg::INTERP_STEPS;
    end
    else if (icnt_reg == 5'h01)
    begin
      // Last step lands exactly; truncation error never accumulates
      sp_next   = tgt_reg;
      icnt_next = 5'h00;
    end
    else if (icnt_reg != 5'h00)
    begin
      sp_next   = sp_reg + step_reg;
      icnt_next = icnt_reg - 5'h01;
    end
  end

  // Status word assembly and parameter reads
  always_comb
  begin
    stat_next = 16'h0000;
    case (state_reg)
      dscw_pkg::ST_SW_DISABLED: stat_next[6:0] = 7'b1000000;
      dscw_pkg::ST_READY:       stat_next[6:0] = 7'b0100001;
      dscw_pkg::ST_SWITCHED_ON: stat_next[6:0] = 7'b0100011;
      dscw_pkg::ST_OP_ENABLED:  stat_next[6:0] = 7'b0100111;
      dscw_pkg::ST_QUICK_STOP:  stat_next[6:0] = 7'b0000111;
      dscw_pkg::ST_FAULT_REACT: stat_next[6:0] = 7'b0001111;
      dscw_pkg::ST_FAULT:       stat_next[6:0] = 7'b0001000;
      default:                  stat_next[6:0] = 7'b0000000;
    endcase
    stat_next[dscw_pkg::SW_VOLTAGE]     = drive_i.dc_ok;
    stat_next[dscw_pkg::SW_WARNING]     = drive_i.warning;
    stat_next[dscw_pkg::SW_HALT]        = ctrl_reg[dscw_pkg::CW_HALT];
    stat_next[dscw_pkg::SW_REMOTE]      = drive_i.remote;
    stat_next[dscw_pkg::SW_MODE_10]     = 1'b0;
    stat_next[dscw_pkg::SW_TARGET_USED] = csp_reg && !ctrl_reg[dscw_pkg::CW_HALT];
    stat_next[dscw_pkg::SW_ERROR]       = (state_reg == dscw_pkg::ST_FAULT_REACT) ||
                                          (state_reg == dscw_pkg::ST_FAULT);
    stat_next[dscw_pkg::SW_END]         = xend_reg;
    stat_next[dscw_pkg::SW_REF_OK]      = drive_i.zero_valid;
    rvalid_next = par_req_i.rd;
    case (par_req_i.addr)
      dscw_pkg::ADDR_CONTROL:  rdata_next = {16'h0000, ctrl_reg};
      dscw_pkg::ADDR_STATUS:   rdata_next = {16'h0000, stat_reg};
      dscw_pkg::ADDR_MODE_SEL: rdata_next = {16'h0000, msel_reg};
      dscw_pkg::ADDR_MODE_ACT: rdata_next = {16'h0000, mact_reg};
      dscw_pkg::ADDR_TARGET:   rdata_next = tgt_reg;
      default:                 rdata_next = 32'h0000_0000;
    endcase
    if (!par_req_i.rd)
      rdata_next = rdata_reg;
  end

  // All state registers
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      ctrl_reg   <= dscw_pkg::CONTROL_RST;
      msel_reg   <= dscw_pkg::MODE_RST;
      mact_reg   <= dscw_pkg::MODE_RST;
      tgt_reg    <= dscw_pkg::TARGET_RST;
      state_reg  <= dscw_pkg::ST_NOT_READY;
      din_reg    <= 2'h0;
      xend_reg   <= 1'b1;
      stat_reg   <= 16'h0000;
      rdata_reg  <= 32'h0000_0000;
      rvalid_reg <= 1'b0;
      pwr_reg    <= 1'b0;
      csp_reg    <= 1'b0;
      sp_reg     <= dscw_pkg::TARGET_RST;
      step_reg   <= 32'h0000_0000;
      icnt_reg   <= 5'h00;
    end
    else
    begin
      ctrl_reg   <= ctrl_next;
      msel_reg   <= msel_next;
      mact_reg   <= mact_next;
      tgt_reg    <= tgt_next;
      state_reg  <= state_next;
      din_reg    <= din_next;
      xend_reg   <= xend_next;
      stat_reg   <= stat_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
      pwr_reg    <= pwr_next;
      csp_reg    <= csp_next;
      sp_reg     <= sp_next;
      step_reg   <= step_next;
      icnt_reg   <= icnt_next;
    end
  end

  assign par_rdata_o    = rdata_reg;
  assign par_rvalid_o   = rvalid_reg;
  assign status_word_o  = stat_reg;
  assign active_mode_o  = mact_reg;
  assign power_stage_o  = pwr_reg;
  assign halt_o         = ctrl_reg[dscw_pkg::CW_HALT];
  assign csp_active_o   = csp_reg;
  assign csp_setpoint_o = sp_reg;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  // Entering operation with a mode selected
  sequence s_enter_run;
    (state_reg != dscw_pkg::ST_OP_ENABLED) ##1 (state_reg == dscw_pkg::ST_OP_ENABLED && mact_reg != 16'h0000);
  endsequence

  property p_halt_bit;
    cw_wr ##1 1'b1 |-> ##1 (status_word_o[8] == $past(cw[8], 2));
  endproperty
  a_halt_bit: assert property (p_halt_bit) else $error("halt status bit wrong");

  property p_error_bit;
    (state_reg == dscw_pkg::ST_FAULT) |=> status_word_o[13];
  endproperty
  a_error_bit: assert property (p_error_bit) else $error("error bit not set in fault");

  property p_end_clear;
    s_enter_run |=> !status_word_o[14];
  endproperty
  a_end_clear: assert property (p_end_clear) else $error("end bit not cleared on start");

  property p_ref_bit;
    1'b1 |=> (status_word_o[15] == $past(drive_i.zero_valid));
  endproperty
  a_ref_bit: assert property (p_ref_bit) else $error("zero point bit wrong");

  property p_enable_fall;
    (state_reg == dscw_pkg::ST_OP_ENABLED && din_fall[0] && !drive_i.err_fatal) |=> (state_reg == dscw_pkg::ST_SW_DISABLED);
  endproperty
  a_enable_fall: assert property (p_enable_fall) else $error("enable input fall ignored");

  property p_shutdown;
    (state_reg == dscw_pkg::ST_SWITCHED_ON && cw_wr && cw[7:0] == 8'h06 && !drive_i.err_fatal)
      |=> (state_reg == dscw_pkg::ST_READY) ##1 status_word_o[0];
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown not reaching ready");

  property p_disable_v;
    (power_on(state_reg) && state_reg != dscw_pkg::ST_FAULT_REACT && cw_wr && cw[7:0] == 8'h00 && !drive_i.err_fatal)
      |=> (state_reg == dscw_pkg::ST_SW_DISABLED) ##1 !power_stage_o;
  endproperty
  a_disable_v: assert property (p_disable_v) else $error("disable voltage failed");

  // Any quick-stop coding counts, not one fixed word
  property p_quick_stop;
    (state_reg == dscw_pkg::ST_OP_ENABLED && cmd_qstop && !din_fall[0] && !drive_i.err_fatal)
      |=> (state_reg == dscw_pkg::ST_QUICK_STOP);
  endproperty
  a_quick_stop: assert property (p_quick_stop) else $error("quick stop not entered");

  property p_fault_reset;
    (state_reg == dscw_pkg::ST_FAULT && fr_edge) |=> (state_reg == dscw_pkg::ST_SW_DISABLED) ##1 status_word_o[6];
  endproperty
  a_fault_reset: assert property (p_fault_reset) else $error("fault reset failed");

  property p_mode_change;
    (mact_reg != $past(mact_reg)) |-> $past(!mode_run || drive_i.standstill);
  endproperty
  a_mode_change: assert property (p_mode_change) else $error("mode changed while running");

  // Running flag must agree with the visible state and active mode
  property p_csp_run;
    csp_active_o == ((state_reg == dscw_pkg::ST_OP_ENABLED) && (active_mode_o == dscw_pkg::MODE_CSP));
  endproperty
  a_csp_run: assert property (p_csp_run) else $error("csp activity wrong");

endmodule : dscw_core

// ===== shared/dscw_pkg.sv
package dscw_pkg;

  // Parameter addresses of the register set
  localparam logic [15:0] ADDR_CONTROL    = 16'h1b02; // drive_control_word
  localparam logic [15:0] ADDR_STATUS     = 16'h1b04; // drive_status_word
  localparam logic [15:0] ADDR_MODE_SEL   = 16'h1b06; // mode_select
  localparam logic [15:0] ADDR_MODE_ACT   = 16'h1b08; // active_mode_readback
  localparam logic [15:0] ADDR_TARGET     = 16'h1b1c; // target_position

  // Reset values
  localparam logic [15:0] CONTROL_RST     = 16'h0000;
  localparam logic [15:0] MODE_RST        = 16'h0000; // Reserved, nothing runs
  localparam logic [31:0] TARGET_RST      = 32'h0000_0000;

  // Control word field positions
  localparam int CW_SWITCH_ON   = 0;
  localparam int CW_EN_VOLTAGE  = 1;
  localparam int CW_QUICK_STOP  = 2;
  localparam int CW_EN_OPER     = 3;
  localparam int CW_FAULT_RESET = 7;
  localparam int CW_HALT        = 8;

  // Status word field positions
  localparam int SW_VOLTAGE     = 4;
  localparam int SW_WARNING     = 7;
  localparam int SW_HALT        = 8;
  localparam int SW_REMOTE      = 9;
  localparam int SW_MODE_10     = 10;
  localparam int SW_TARGET_USED = 12;
  localparam int SW_ERROR       = 13;
  localparam int SW_END         = 14;
  localparam int SW_REF_OK      = 15;

  // Operating mode encodings
  localparam logic [15:0] MODE_JOG  = 16'hffff;
  localparam logic [15:0] MODE_NONE = 16'h0000;
  localparam logic [15:0] MODE_PP   = 16'h0001;
  localparam logic [15:0] MODE_PV   = 16'h0003;
  localparam logic [15:0] MODE_HOME = 16'h0006;
  localparam logic [15:0] MODE_CSP  = 16'h0008;

  // Interpolation: each received position is reached in 2**INTERP_SHIFT clocks
  localparam int          INTERP_SHIFT = 4;
  localparam logic [4:0]  INTERP_STEPS = 5'h10;

  // Operating states, codes equal to the state numbers
  typedef enum logic [3:0] {
    ST_NOT_READY   = 4'b0010,
    ST_SW_DISABLED = 4'b0011,
    ST_READY       = 4'b0100,
    ST_SWITCHED_ON = 4'b0101,
    ST_OP_ENABLED  = 4'b0110,
    ST_QUICK_STOP  = 4'b0111,
    ST_FAULT_REACT = 4'b1000,
    ST_FAULT       = 4'b1001
  } dscw_state_t;

  // One parameter access from the fieldbus
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } dscw_par_req_t;

  // Drive-side conditions fed in from the motion core
  typedef struct packed {
    logic dc_ok;        // DC bus voltage correct
    logic warning;      // Error class 0 message present
    logic remote;       // Fieldbus is the controlling channel
    logic standstill;   // Motor at standstill
    logic zero_valid;   // Valid zero point held
    logic err_class1;   // Error of class 1 detected
    logic err_fatal;    // Error of class 2..4 detected
    logic react_done;   // Error response finished
  } dscw_drive_t;

endpackage : dscw_pkg

// ===== sim/drive_state_control_word_bench.sv
module drive_state_control_word_bench;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fail_count++; $display("wrong value %s exp %h got %h", n, e, s); end end

  logic                    ref_clk_i = 1'b0;  // 50 MHz
  logic                    rstn_i    = 1'b0;  // Active low reset
  logic                    din_en    = 1'b0;  // Power-enable input
  logic                    din_fr    = 1'b0;  // Error-reset input
  dscw_pkg::dscw_drive_t   drv       = 8'hb8; // Remote, standstill, zero valid
  dscw_pkg::dscw_par_req_t req;               // From master model
  logic [31:0]             rdata, sp, rv;     // Read data, setpoint, read value
  logic                    rvalid, pwr, halt, csp;
  logic [15:0]             sw, act;
  wire  [15:0]             st = sw & 16'h006f; // State bits only
  int                      fail_count = 0;
  int                      checked = 0;
  int                      cyc = 0;

  // Free running clock
  always #10 ref_clk_i = ~ref_clk_i;

  dscw_core dut_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .par_req_i(req), .din_enable_i(din_en),
    .din_fault_rst_i(din_fr), .drive_i(drv), .par_rdata_o(rdata), .par_rvalid_o(rvalid),
    .status_word_o(sw), .active_mode_o(act), .power_stage_o(pwr), .halt_o(halt),
    .csp_active_o(csp), .csp_setpoint_o(sp));
  dscw_master master_u (.clk_i(ref_clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));

  // Control write, then wait for the status to follow
  task automatic step(input logic [15:0] cw);
    master_u.wr(dscw_pkg::ADDR_CONTROL, {16'h0000, cw});
    repeat (3) @(negedge ref_clk_i);
  endtask : step

  task automatic t_reset();
    `CHK("state", 16'h0040, st)
    `CHK("end", 1'b1, sw[14])
    `CHK("remote", 1'b1, sw[9])
    `CHK("ref", 1'b1, sw[15])
    `CHK("err", 1'b0, sw[13])
    `CHK("act_o", 16'h0000, act)
    `CHK("pwr", 1'b0, pwr)
  endtask : t_reset

  // Select CSP while stopped, then walk up to operation enabled
  task automatic t_run();
    master_u.wr(dscw_pkg::ADDR_MODE_SEL, {16'h0000, dscw_pkg::MODE_CSP});
    master_u.rd(dscw_pkg::ADDR_MODE_ACT, rv);
    `CHK("act", 32'h0000_0008, rv)
    master_u.rd(16'h1b0a, rv);
    `CHK("unmapped", 32'h0000_0000, rv)
    step(16'h0006);
    `CHK("ready", 16'h0021, st)
    step(16'h0007);
    `CHK("on", 16'h0023, st)
    step(16'h000f);
    `CHK("enabled", 16'h0027, st)
    `CHK("csp", 1'b1, csp)
    `CHK("pwr", 1'b1, pwr)
    `CHK("act_o", 16'h0008, act)
    `CHK("end", 1'b0, sw[14])
    `CHK("used", 1'b1, sw[12])
    `CHK("rsvd", 1'b0, sw[10])
  endtask : t_run

  // Position must ramp, not jump
  task automatic t_csp();
    master_u.wr(dscw_pkg::ADDR_TARGET, 32'h0000_0160);
    repeat (4) @(negedge ref_clk_i);
    `CHK("ramp", 1'b1, sp < 32'h0000_0160)
    repeat (20) @(negedge ref_clk_i);
    `CHK("land", 32'h0000_0160, sp)
  endtask : t_csp

  task automatic t_halt();
    step(16'h010f);
    `CHK("halt", 1'b1, sw[8])
    `CHK("halt_o", 1'b1, halt)
    `CHK("used", 1'b0, sw[12])
    `CHK("end", 1'b1, sw[14])
    // Another channel in control and no zero point: both bits must drop
    drv = 8'h90;
    repeat (2) @(negedge ref_clk_i);
    `CHK("remote", 1'b0, sw[9])
    `CHK("ref", 1'b0, sw[15])
    drv = 8'hb8;
    step(16'h000f);
    `CHK("halt", 1'b0, sw[8])
  endtask : t_halt

  // Quick stop, then out of it by the reset input
  task automatic t_qstop();
    step(16'h000b);
    `CHK("qstop", 16'h0007, st)
    din_fr = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    `CHK("back", 16'h0027, st)
    din_fr = 1'b0;
  endtask : t_qstop

  // Enable input: rise only counts from ready
  task automatic t_din();
    din_en = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    din_en = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    `CHK("off", 16'h0040, st)
    `CHK("csp", 1'b0, csp)
    `CHK("pwr", 1'b0, pwr)
    step(16'h0006);
    din_en = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    `CHK("on", 16'h0023, st)
    step(16'h0006);
    `CHK("down", 16'h0021, st)
    step(16'h0007);
    step(16'h000f);
    `CHK("enabled", 16'h0027, st)
    `CHK("pwr", 1'b1, pwr)
    // Disable voltage straight out of operation
    step(16'h0000);
    `CHK("dis", 16'h0040, st)
    `CHK("pwr", 1'b0, pwr)
  endtask : t_din

  // Fatal error, reaction finishes, fault state
  task automatic to_fault();
    drv.err_fatal = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    `CHK("react", 16'h000f, sw & 16'h004f)
    `CHK("err", 1'b1, sw[13])
    drv = 8'hb9;
    repeat (3) @(negedge ref_clk_i);
    `CHK("fault", 16'h0008, sw & 16'h004f)
    drv = 8'hb8;
  endtask : to_fault

  task automatic t_fault();
    to_fault();
    step(16'h0080);
    `CHK("freset", 16'h0040, st)
    to_fault();
    din_fr = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    `CHK("inreset", 16'h0040, st)
  endtask : t_fault

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // Hang guard, far above the roughly 140 cycles used
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      fail_count++;
      close_out();
    end
  end

  initial
  begin
    repeat (3) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    t_reset();
    t_run();
    t_csp();
    t_halt();
    t_qstop();
    t_din();
    t_fault();
    // Reset again in mid-run: everything must come back clean
    rstn_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    t_reset();
    close_out();
  end
endmodule : drive_state_control_word_bench

// ===== sim/dscw_master.sv
// Fieldbus master: one parameter access per call
module dscw_master (
  input  wire logic                    clk_i,    // Drive clock
  input  wire logic [31:0]             rdata_i,  // Read data from the drive
  input  wire logic                    rvalid_i, // Read data valid pulse
  output dscw_pkg::dscw_par_req_t      req_o     // Access request
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus until the first call
  initial req_o = '0;

  // Write held across one rising edge; control word reserved and mode bits forced low
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] v;
    v = (a == dscw_pkg::ADDR_CONTROL) ? (d & 32'h0000_018f) : d;
    @(negedge clk_i);
    req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(negedge clk_i);
    req_o = '0;
  endtask : wr

  // Read; answer caught within a few cycles, else left unknown
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    int n;
    d = 32'hxxxx_xxxx;
    @(negedge clk_i);
    req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(negedge clk_i);
    req_o = '0;
    for (n = 0; n < 4; n++)
    begin
      if (rvalid_i === 1'b1)
        d = rdata_i;
      @(negedge clk_i);
    end
  endtask : rd
endmodule : dscw_master
